/* File: rtcc_consts.vh */
/*
 Register indices, field positions, reset values and timing figures
 of the real-time counter block. Assumes an APB slave that maps each
 register index to byte address index*4.
*/
//
// Function
// - Sign bit clear slows the prescaler by swallowing correction clocks.
// - Sign bit set speeds the prescaler; software must use divide_by_two or more.
// - Seven-bit magnitude is correction clocks per million counter clocks.
// - Two-bit clock_source_field picks fast, slow, crystal or external pin source.
// - Counter is two bytes, low then high, resets to zero, writable.
// - Counter and period writes reach the counter domain after two counter clocks.
// - Period is low and high byte at consecutive indices, resets to all ones.
// - Compare is low and high byte at consecutive indices, resets to zero.
// - Interval field bits 6:3: zero off, 1..14 give 4..32768 cycles, 15 reserved.
// - periodic_timer_on in bit 0 switches the periodic timer on or off.
// - periodic_ctrl_sync_pending reads one while a control write is synchronised.
// - Correction is applied only while correction_enable is set.
// - wrap_flag sets when counter reaches period and wraps; write one clears.
// - Compare flag sets when counter equals compare; write one clears.
// - periodic_event_flag sets on each periodic event; write one clears.
`ifndef RTCC_CONSTS_VH
`define RTCC_CONSTS_VH

// ****************************************************************
// Register indices (byte address is index times four)
// ****************************************************************
`define RTCC_IDX_CTRL 6'h00
`define RTCC_IDX_STATUS 6'h01
`define RTCC_IDX_IMASK 6'h02
`define RTCC_IDX_IFLAG 6'h03
`define RTCC_IDX_CORR 6'h06
`define RTCC_IDX_CLKSRC 6'h07
`define RTCC_IDX_CNTL 6'h08
`define RTCC_IDX_CNTH 6'h09
`define RTCC_IDX_PERL 6'h0A
`define RTCC_IDX_PERH 6'h0B
`define RTCC_IDX_CMPL 6'h0C
`define RTCC_IDX_CMPH 6'h0D
`define RTCC_IDX_PITCTRL 6'h10
`define RTCC_IDX_PITSTAT 6'h11
`define RTCC_IDX_PITMASK 6'h12
`define RTCC_IDX_PITFLAG 6'h13

// ****************************************************************
// Field positions
// ****************************************************************
`define RTCC_CTRL_EN 0
`define RTCC_CTRL_CORRECTION_ENABLE 2
`define RTCC_CTRL_DIV_LSB 3
`define RTCC_CORR_SIGN 7
`define RTCC_FLAG_WRAP 0
`define RTCC_FLAG_CMP 1
`define RTCC_STAT_CNT 1
`define RTCC_STAT_PER 2
`define RTCC_PIT_ON 0
`define RTCC_PIT_IVL_LSB 3

// ****************************************************************
// Reset values and codes
// ****************************************************************
`define RTCC_CNT_RST 16'h0000
`define RTCC_PER_RST 16'hFFFF
`define RTCC_CMP_RST 16'h0000
`define RTCC_IVL_OFF 4'h0
`define RTCC_IVL_RSVD 4'hF
`define RTCC_SRC_FAST 2'h0
`define RTCC_SRC_SLOW 2'h1
`define RTCC_SRC_XTAL 2'h2
`define RTCC_SRC_EXT 2'h3

// ****************************************************************
// Timing
// ****************************************************************
`define RTCC_SYNC_TICKS 2'd2
`define RTCC_PPM_SPAN 20'd1000000

`endif

/* File: rtcc_presc.v */
/*
 Prescaler with crystal correction. Produces the counter advance pulse.
 Assumes tick is one pulse per selected counter clock edge.
*/
`timescale 1ns/1ps
module rtcc_presc (
  input wire clk,
  input wire rst,
  input wire tick,
  input wire [3:0] div,
  input wire corr_en,
  input wire sign,
  input wire [6:0] err,
  output reg adv
);
`include "rtcc_consts.vh"

  reg [15:0] pcount;
  reg [19:0] ppm_acc;
  reg [19:0] next_acc;
  reg [1:0] step;
  reg [15:0] next_pcount;
  reg corr_due;

  // ****************************************************************
  // Correction accumulator over each million counter clocks
  // ****************************************************************
  always @* begin
    next_acc = ppm_acc + {13'd0, err};
    corr_due = corr_en && (next_acc >= `RTCC_PPM_SPAN);
    if (!corr_due)
      step = 2'd1;
    else if (sign)
      step = 2'd2;
    else
      step = 2'd0;
    next_pcount = pcount + {14'd0, step};
  end

  always @(posedge clk) begin
    if (rst) begin
      pcount <= 16'h0000;
      ppm_acc <= 20'd0;
      adv <= 1'b0;
    end else begin
      adv <= 1'b0;
      if (tick) begin
        ppm_acc <= corr_due ? next_acc - `RTCC_PPM_SPAN :
                   (corr_en ? next_acc : 20'd0);
        pcount <= next_pcount;
        // Advance when the count shifted right by div changes
        adv <= ((next_pcount >> div) != (pcount >> div));
      end
    end
  end
endmodule

/* File: rtcc_sync.v */
/*
 Write crossing for one register into the counter clock domain.
 Assumes tick is a one-cycle pulse per counter clock edge.
*/
`timescale 1ns/1ps
module rtcc_sync #(
  parameter W = 16
) (
  input wire clk,
  input wire rst,
  input wire wr,
  input wire [W-1:0] wdata,
  input wire tick,
  output reg busy,
  output reg apply,
  output reg [W-1:0] data
);
`include "rtcc_consts.vh"

  reg [1:0] seen;

  // ****************************************************************
  // Hold value, count two counter clocks, then apply
  // ****************************************************************
  always @(posedge clk) begin
    if (rst) begin
      busy <= 1'b0;
      apply <= 1'b0;
      seen <= 2'd0;
      data <= {W{1'b0}};
    end else begin
      apply <= 1'b0;
      if (wr) begin
        // A new write restarts the wait
        busy <= 1'b1;
        seen <= 2'd0;
        data <= wdata;
      end else if (busy && tick) begin
        if (seen + 2'd1 == `RTCC_SYNC_TICKS) begin
          busy <= 1'b0;
          apply <= 1'b1;
        end
        seen <= seen + 2'd1;
      end
    end
  end
endmodule

/* File: rtcc_top.v */
/*
 Real-time counter register block: APB slave, clock source select,
 counter, period, compare, periodic timer and interrupt.
 Assumes the four source inputs are levels synchronous to clk and
 much slower than it; each rising edge of the chosen one is a
 counter clock.
*/
`timescale 1ns/1ps
module rtcc_top (
  input wire clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire internal_fast_osc,
  input wire internal_slow_osc,
  input wire crystal_osc,
  input wire external_clock_pin,
  output reg irq
);
`include "rtcc_consts.vh"

  // ****************************************************************
  // Register state
  // ****************************************************************
  reg [7:0] ctrl;
  reg [7:0] crystal_correction;
  reg [1:0] clock_source_field;
  reg [15:0] counter_value;
  reg [15:0] period_value;
  reg [15:0] compare_value;
  reg [7:0] periodic_timer_control;
  reg [15:0] period_live;
  reg [7:0] pit_live;
  reg [1:0] flags;
  reg [1:0] mask;
  reg periodic_event_flag;
  reg pit_mask;
  reg src_prev;
  reg rtc_tick;
  reg [14:0] pit_count;

  wire access = psel && penable && pready;
  wire wr_en = access && pwrite;
  wire [5:0] idx = paddr[7:2];
  wire [7:0] wb = pwdata[7:0];
  wire cnt_busy;
  wire cnt_apply;
  wire [15:0] cnt_data;
  wire per_busy;
  wire per_apply;
  wire [15:0] per_data;
  wire pit_busy;
  wire pit_apply;
  wire [7:0] pit_data;
  wire adv;

  // ****************************************************************
  // Address decode, shared by read and error answer
  // ****************************************************************
  function mapped;
    input [5:0] i;
    begin
      case (i)
        `RTCC_IDX_CTRL, `RTCC_IDX_STATUS, `RTCC_IDX_IMASK,
        `RTCC_IDX_IFLAG, `RTCC_IDX_CORR, `RTCC_IDX_CLKSRC,
        `RTCC_IDX_CNTL, `RTCC_IDX_CNTH, `RTCC_IDX_PERL,
        `RTCC_IDX_PERH, `RTCC_IDX_CMPL, `RTCC_IDX_CMPH,
        `RTCC_IDX_PITCTRL, `RTCC_IDX_PITSTAT, `RTCC_IDX_PITMASK,
        `RTCC_IDX_PITFLAG: mapped = 1'b1;
        default: mapped = 1'b0;
      endcase
    end
  endfunction

  function wr_at;
    input [5:0] i;
    begin
      wr_at = wr_en && (idx == i);
    end
  endfunction

  // ****************************************************************
  // Counter clock source and edge
  // ****************************************************************
  reg src_now;
  always @* begin
    case (clock_source_field)
      `RTCC_SRC_FAST: src_now = internal_fast_osc;
      `RTCC_SRC_SLOW: src_now = internal_slow_osc;
      `RTCC_SRC_XTAL: src_now = crystal_osc;
      default: src_now = external_clock_pin;
    endcase
  end

  // A source switch may yield one stray tick; harmless for a counter
  always @(posedge clk) begin
    if (rst) begin
      src_prev <= 1'b0;
      rtc_tick <= 1'b0;
    end else begin
      src_prev <= src_now;
      rtc_tick <= src_now && !src_prev;
    end
  end

  // ****************************************************************
  // Write crossings into the counter domain
  // ****************************************************************
  rtcc_sync #(.W(16)) u_cnt_sync (
    .clk(clk),
    .rst(rst),
    .wr(wr_at(`RTCC_IDX_CNTL) || wr_at(`RTCC_IDX_CNTH)),
    .wdata(wr_at(`RTCC_IDX_CNTL) ? {counter_value[15:8], wb} :
           {wb, counter_value[7:0]}),
    .tick(rtc_tick),
    .busy(cnt_busy),
    .apply(cnt_apply),
    .data(cnt_data)
  );

  rtcc_sync #(.W(16)) u_per_sync (
    .clk(clk),
    .rst(rst),
    .wr(wr_at(`RTCC_IDX_PERL) || wr_at(`RTCC_IDX_PERH)),
    .wdata(wr_at(`RTCC_IDX_PERL) ? {period_value[15:8], wb} :
           {wb, period_value[7:0]}),
    .tick(rtc_tick),
    .busy(per_busy),
    .apply(per_apply),
    .data(per_data)
  );

  rtcc_sync #(.W(8)) u_pit_sync (
    .clk(clk),
    .rst(rst),
    .wr(wr_at(`RTCC_IDX_PITCTRL)),
    .wdata({1'b0, wb[6:3], 2'b00, wb[0]}),
    .tick(rtc_tick),
    .busy(pit_busy),
    .apply(pit_apply),
    .data(pit_data)
  );

  // ****************************************************************
  // Prescaler with correction
  // ****************************************************************
  rtcc_presc u_presc (
    .clk(clk),
    .rst(rst),
    .tick(rtc_tick && ctrl[`RTCC_CTRL_EN]),
    .div(ctrl[`RTCC_CTRL_DIV_LSB+3:`RTCC_CTRL_DIV_LSB]),
    .corr_en(ctrl[`RTCC_CTRL_CORRECTION_ENABLE]),
    .sign(crystal_correction[`RTCC_CORR_SIGN]),
    .err(crystal_correction[6:0]),
    .adv(adv)
  );

  // ****************************************************************
  // Periodic timer event
  // ****************************************************************
  wire [3:0] ivl = pit_live[`RTCC_PIT_IVL_LSB+3:`RTCC_PIT_IVL_LSB];
  wire pit_run = pit_live[`RTCC_PIT_ON] && (ivl != `RTCC_IVL_OFF) &&
                 (ivl != `RTCC_IVL_RSVD);
  // Code n gives 2^(n+1) counter clocks between events
  wire [14:0] ivl_mask = (15'h7FFF >> (4'd14 - ivl));
  wire pit_event = rtc_tick && pit_run &&
                   ((pit_count & ivl_mask) == ivl_mask);

  always @(posedge clk) begin
    if (rst) begin
      pit_count <= 15'h0000;
    end else if (!pit_run) begin
      pit_count <= 15'h0000;
    end else if (rtc_tick) begin
      pit_count <= pit_count + 15'h0001;
    end
  end

  // ****************************************************************
  // Counter, period and periodic timer control in the counter domain
  // ****************************************************************
  wire wrap_hit = adv && (counter_value == period_live);
  wire [15:0] next_count = wrap_hit ? 16'h0000 :
                           counter_value + 16'h0001;

  always @(posedge clk) begin
    if (rst) begin
      counter_value <= `RTCC_CNT_RST;
      period_live <= `RTCC_PER_RST;
      pit_live <= 8'h00;
    end else begin
      if (cnt_apply) begin
        counter_value <= cnt_data;
      end else if (adv) begin
        counter_value <= next_count;
      end
      if (per_apply) begin
        period_live <= per_data;
      end
      if (pit_apply) begin
        pit_live <= pit_data;
      end
    end
  end

  // ****************************************************************
  // Software registers
  // ****************************************************************
  always @(posedge clk) begin
    if (rst) begin
      ctrl <= 8'h00;
      crystal_correction <= 8'h00;
      clock_source_field <= `RTCC_SRC_FAST;
      period_value <= `RTCC_PER_RST;
      compare_value <= `RTCC_CMP_RST;
      periodic_timer_control <= 8'h00;
      mask <= 2'b00;
      pit_mask <= 1'b0;
    end else begin
      if (wr_at(`RTCC_IDX_CTRL))
        ctrl <= {1'b0, wb[6:3], wb[2], 1'b0, wb[0]};
      if (wr_at(`RTCC_IDX_CORR))
        crystal_correction <= wb;
      if (wr_at(`RTCC_IDX_CLKSRC))
        clock_source_field <= wb[1:0];
      if (wr_at(`RTCC_IDX_PERL))
        period_value[7:0] <= wb;
      if (wr_at(`RTCC_IDX_PERH))
        period_value[15:8] <= wb;
      if (wr_at(`RTCC_IDX_CMPL))
        compare_value[7:0] <= wb;
      if (wr_at(`RTCC_IDX_CMPH))
        compare_value[15:8] <= wb;
      if (wr_at(`RTCC_IDX_PITCTRL))
        periodic_timer_control <= {1'b0, wb[6:3], 2'b00, wb[0]};
      if (wr_at(`RTCC_IDX_IMASK))
        mask <= wb[1:0];
      if (wr_at(`RTCC_IDX_PITMASK))
        pit_mask <= wb[0];
    end
  end

  // ****************************************************************
  // Event flags: a set in the clearing cycle wins
  // ****************************************************************
  wire cmp_hit = adv && !cnt_apply && (next_count == compare_value);
  wire [1:0] flag_set;
  wire [1:0] flag_clr;
  assign flag_set[`RTCC_FLAG_WRAP] = wrap_hit && !cnt_apply;
  assign flag_set[`RTCC_FLAG_CMP] = cmp_hit;
  assign flag_clr = wr_at(`RTCC_IDX_IFLAG) ? wb[1:0] : 2'b00;

  always @(posedge clk) begin
    if (rst) begin
      flags <= 2'b00;
      periodic_event_flag <= 1'b0;
      irq <= 1'b0;
    end else begin
      flags <= (flags & ~flag_clr) | flag_set;
      if (pit_event)
        periodic_event_flag <= 1'b1;
      else if (wr_at(`RTCC_IDX_PITFLAG) && wb[0])
        periodic_event_flag <= 1'b0;
      irq <= |(flags & mask) || (periodic_event_flag && pit_mask);
    end
  end

  // ****************************************************************
  // APB answer: one wait state, registered data
  // ****************************************************************
  reg [7:0] rd;
  always @* begin
    case (idx)
      `RTCC_IDX_CTRL: rd = ctrl;
      `RTCC_IDX_STATUS: rd = {5'd0, per_busy, cnt_busy, 1'b0};
      `RTCC_IDX_IMASK: rd = {6'd0, mask};
      `RTCC_IDX_IFLAG: rd = {6'd0, flags};
      `RTCC_IDX_CORR: rd = crystal_correction;
      `RTCC_IDX_CLKSRC: rd = {6'd0, clock_source_field};
      `RTCC_IDX_CNTL: rd = counter_value[7:0];
      `RTCC_IDX_CNTH: rd = counter_value[15:8];
      `RTCC_IDX_PERL: rd = period_value[7:0];
      `RTCC_IDX_PERH: rd = period_value[15:8];
      `RTCC_IDX_CMPL: rd = compare_value[7:0];
      `RTCC_IDX_CMPH: rd = compare_value[15:8];
      `RTCC_IDX_PITCTRL: rd = periodic_timer_control;
      `RTCC_IDX_PITSTAT: rd = {7'd0, pit_busy};
      `RTCC_IDX_PITMASK: rd = {7'd0, pit_mask};
      `RTCC_IDX_PITFLAG: rd = {7'd0, periodic_event_flag};
      default: rd = 8'h00;
    endcase
  end

  always @(posedge clk) begin
    if (rst) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      if (psel && penable && !pready) begin
        pready <= 1'b1;
        prdata <= (!pwrite && mapped(idx)) ? {24'd0, rd} : 32'h00000000;
        pslverr <= !mapped(idx);
      end else begin
        pready <= 1'b0;
        pslverr <= 1'b0;
      end
    end
  end
endmodule

/* File: rtcc_top_asserts.sv */
/*
 Port checker for rtcc_top: APB answer timing, error answers,
 sync busy reporting and interrupt release.
 Assumes an APB master that leaves one idle cycle between transfers.
*/
`timescale 1ns/1ps
`include "rtcc_consts.vh"
module rtcc_top_chk (
  input wire clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire irq
);
  // ****************************************
  // Helpers and properties
  // ****************************************
  wire [5:0] idx = paddr[7:2];
  wire take = psel && penable && pready;
  wire wtake = take && pwrite;
  wire rd_st = take && !pwrite && idx == `RTCC_IDX_STATUS;
  wire rd_pst = take && !pwrite && idx == `RTCC_IDX_PITSTAT;
  wire hole = idx == 6'h04 || idx == 6'h05 || idx == 6'h0E ||
    idx == 6'h0F || idx > 6'h13;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  property p_answer;
    (psel && !penable) ##1 (psel && penable) |=> pready;
  endproperty
  a_answer: assert property (p_answer) else $error("pready late");
  property p_pulse;
    pready |=> !pready;
  endproperty
  a_pulse: assert property (p_pulse) else $error("pready too long");
  property p_err_pair;
    pslverr |-> take;
  endproperty
  a_err_pair: assert property (p_err_pair) else $error("stray pslverr");
  property p_hole;
    take |-> pslverr == hole;
  endproperty
  a_hole: assert property (p_hole) else $error("pslverr vs map");
  property p_upper;
    take && !pwrite |-> prdata[31:8] == 24'h0;
  endproperty
  a_upper: assert property (p_upper) else $error("prdata upper bits");
  property p_cnt_busy;
    (wtake && idx == `RTCC_IDX_CNTL) ##4 rd_st |-> prdata[1];
  endproperty
  a_cnt_busy: assert property (p_cnt_busy) else $error("cnt busy");
  property p_per_busy;
    (wtake && idx == `RTCC_IDX_PERH) ##4 rd_st |-> prdata[2];
  endproperty
  a_per_busy: assert property (p_per_busy) else $error("per busy");
  property p_pit_busy;
    (wtake && idx == `RTCC_IDX_PITCTRL) ##4 rd_pst |-> prdata[0];
  endproperty
  a_pit_busy: assert property (p_pit_busy) else $error("pit busy");
  property p_irq_fall;
    $fell(irq) |-> $past(wtake) || $past(wtake, 2);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell");
endmodule
bind rtcc_top rtcc_top_chk u_rtcc_top_chk (
  .clk(clk),
  .rst(rst),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .irq(irq)
);

/* File: rtcc_top_tb.sv */
/*
 Self-checking bench for rtcc_top: register table, clock sources,
 counter wrap and compare, periodic timer, interrupt line, reset.
 Assumes the port checker is bound in from its own file. Correction
 runs one full interval each way after the mid-run reset, which clears
 the prescaler; that part dominates the run time.
*/
`timescale 1ns/1ps
`include "rtcc_consts.vh"
module rtcc_top_tb;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [7:0] paddr = 8'h00;
  reg [31:0] pwdata = 32'h0;
  reg [3:0] src = 4'h0;
  wire [31:0] prdata;
  wire pready;
  wire pslverr;
  wire irq;
  integer n_fail = 0;
  integer checks_done = 0;
  integer i;
  integer k;
  reg [31:0] rd;
  reg err;
  reg [39:0] rows [0:14];
  reg [15:0] pits [0:4];
  rtcc_top u_rtcc_top (
    .clk(clk),
    .rst(rst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .internal_fast_osc(src[0]),
    .internal_slow_osc(src[1]),
    .crystal_osc(src[2]),
    .external_clock_pin(src[3]),
    .irq(irq)
  );
  always #25 clk = ~clk;
  // ****************************************
  // Tasks
  // ****************************************
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d failures %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  task bail;
    begin
      n_fail = n_fail + 1;
      $display("ERROR %0t wait ran out", $time);
      end_of_test;
    end
  endtask
  task apb(input w, input [5:0] a, input [7:0] d);
    integer t;
    begin
      t = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {a, 2'b00};
      pwdata <= {24'h0, d};
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && t < 20) begin
        @(posedge clk);
        t = t + 1;
      end
      if (t == 20)
        bail;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  // Edges held three cycles each: the design needs one at least
  task pulse(input [1:0] s, input [3:0] n);
    integer j;
    begin
      for (j = 0; j < n; j = j + 1) begin
        @(posedge clk);
        src[s] <= 1'b1;
        repeat (3) @(posedge clk);
        src[s] <= 1'b0;
        repeat (3) @(posedge clk);
      end
    end
  endtask
  task settle(input [5:0] a, input [1:0] s);
    integer t;
    begin
      t = 0;
      apb(0, a, 8'h00);
      while (rd[2:0] !== 3'b000 && t < 8) begin
        pulse(s, 1);
        apb(0, a, 8'h00);
        t = t + 1;
      end
      if (t == 8)
        bail;
    end
  endtask
  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    // index, reset value, write value, readback, error
    rows[0] = 40'h01_00_FF_00_00;
    rows[1] = 40'h11_00_FF_00_00;
    rows[2] = 40'h04_00_55_00_01;
    rows[3] = 40'h14_00_55_00_01;
    rows[4] = 40'h06_00_A5_A5_00;
    rows[5] = 40'h07_00_02_02_00;
    rows[6] = 40'h0C_00_5A_5A_00;
    rows[7] = 40'h0D_00_C3_C3_00;
    rows[8] = 40'h02_00_03_03_00;
    rows[9] = 40'h12_00_01_01_00;
    rows[10] = 40'h03_00_00_00_00;
    rows[11] = 40'h0A_FF_12_12_00;
    rows[12] = 40'h0B_FF_34_34_00;
    rows[13] = 40'h08_00_77_00_00;
    rows[14] = 40'h09_00_00_00_00;
    // control, pulses, expected periodic flag
    pits[0] = 16'h0941;
    pits[1] = 16'h1181;
    pits[2] = 16'h0880;
    pits[3] = 16'h0180;
    pits[4] = 16'h7980;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 15; i = i + 1) begin
      apb(0, rows[i][37:32], 8'h00);
      chk(rd, {24'h0, rows[i][31:24]});
      apb(1, rows[i][37:32], rows[i][23:16]);
      chk({31'h0, err}, {31'h0, rows[i][0]});
      apb(0, rows[i][37:32], 8'h00);
      chk(rd, {24'h0, rows[i][15:8]});
    end
    apb(1, `RTCC_IDX_CLKSRC, 8'h00);
    apb(1, `RTCC_IDX_PERL, 8'h05);
    settle(`RTCC_IDX_STATUS, 2'd0);
    apb(1, `RTCC_IDX_PERH, 8'h00);
    apb(0, `RTCC_IDX_STATUS, 8'h00);
    chk(rd & 32'h4, 32'h4);
    settle(`RTCC_IDX_STATUS, 2'd0);
    apb(1, `RTCC_IDX_CNTL, 8'h01);
    apb(0, `RTCC_IDX_STATUS, 8'h00);
    chk(rd & 32'h2, 32'h2);
    settle(`RTCC_IDX_STATUS, 2'd0);
    apb(1, `RTCC_IDX_CMPL, 8'h03);
    apb(1, `RTCC_IDX_CMPH, 8'h00);
    apb(1, `RTCC_IDX_IMASK, 8'h00);
    apb(1, `RTCC_IDX_IFLAG, 8'h03);
    // Sign bit set is only legal with divide_by_two or more
    apb(1, `RTCC_IDX_CORR, 8'h00);
    apb(1, `RTCC_IDX_CTRL, 8'h01);
    pulse(2'd0, 4'd3);
    apb(0, `RTCC_IDX_CNTL, 8'h00);
    chk(rd, 32'h4);
    apb(0, `RTCC_IDX_IFLAG, 8'h00);
    chk(rd, 32'h2);
    chk({31'h0, irq}, 32'h0);
    apb(1, `RTCC_IDX_IMASK, 8'h02);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    apb(1, `RTCC_IDX_IFLAG, 8'h02);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    pulse(2'd0, 4'd3);
    apb(0, `RTCC_IDX_CNTL, 8'h00);
    chk(rd, 32'h1);
    apb(0, `RTCC_IDX_IFLAG, 8'h00);
    chk(rd, 32'h1);
    apb(1, `RTCC_IDX_IMASK, 8'h01);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    apb(1, `RTCC_IDX_IFLAG, 8'h01);
    apb(1, `RTCC_IDX_IMASK, 8'h00);
    // Pulses on an unselected source must not move the counter
    for (i = 0; i < 4; i = i + 1) begin
      apb(1, `RTCC_IDX_CLKSRC, i[7:0]);
      apb(0, `RTCC_IDX_CNTL, 8'h00);
      k = (rd + 2) % 6;
      pulse(i[1:0] + 2'd1, 4'd2);
      pulse(i[1:0], 4'd2);
      apb(0, `RTCC_IDX_CNTL, 8'h00);
      chk(rd, k);
    end
    apb(0, `RTCC_IDX_PITCTRL, 8'h00);
    chk(rd, 32'h0);
    for (i = 0; i < 5; i = i + 1) begin
      apb(1, `RTCC_IDX_PITCTRL, pits[i][15:8]);
      apb(0, `RTCC_IDX_PITSTAT, 8'h00);
      chk(rd, 32'h1);
      settle(`RTCC_IDX_PITSTAT, 2'd3);
      apb(0, `RTCC_IDX_PITCTRL, 8'h00);
      chk(rd, {24'h0, pits[i][15:8]});
      apb(1, `RTCC_IDX_PITFLAG, 8'h01);
      pulse(2'd3, pits[i][7:4]);
      apb(0, `RTCC_IDX_PITFLAG, 8'h00);
      chk(rd, {28'h0, pits[i][3:0]});
      chk({31'h0, irq}, {28'h0, pits[i][3:0]});
    end
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    apb(0, `RTCC_IDX_PERH, 8'h00);
    chk(rd, 32'hFF);
    apb(0, `RTCC_IDX_PITFLAG, 8'h00);
    chk(rd, 32'h0);
    chk({31'h0, irq}, 32'h0);
    // 7875 ticks of 127 per million: one correction each pass
    for (i = 0; i < 2; i = i + 1) begin
      apb(1, `RTCC_IDX_CTRL, i ? 8'h0D : 8'h05);
      apb(1, `RTCC_IDX_CORR, i ? 8'hFF : 8'h7F);
      for (k = 0; k < 7875; k = k + 1) begin
        src[0] <= 1'b1;
        repeat (2) @(posedge clk);
        src[0] <= 1'b0;
        repeat (2) @(posedge clk);
      end
      apb(0, `RTCC_IDX_CNTL, 8'h00);
      chk(rd, i ? 32'h24 : 32'hC2);
      apb(0, `RTCC_IDX_CNTH, 8'h00);
      chk(rd, i ? 32'h2E : 32'h1E);
    end
    end_of_test;
  end
endmodule
